// ==== rtl/csvr_clk_src.v ====
// counter clock source and prescaler for the gated counter
// assumes core_clk stands for the system oscillator; slow clock is an eighth of it, a quarter of the fast clock
`timescale 1ns/1ps
`default_nettype none
`include "csvr_map.vh"

module csvr_clk_src
(
   // clock and reset
   input  wire       core_clk,
   input  wire       rst_b,
   // selects
   input  wire       fastSel,
   input  wire [1:0] prescale,
   // prescaled clock edges, one-cycle pulses
   output reg        psRise,
   output reg        psFall
);

   reg  [1:0] divCnt_ff;   // slow-clock half period counter
   reg        rawClk_ff;   // raw counter clock level
   reg  [2:0] psCnt_ff;    // prescaler ripple count
   reg        psLvlD_ff;   // prescaled level, one cycle late
   wire       rawToggle;   // raw clock flips this cycle
   reg        psLvl;       // prescaled clock level

   // fast clock flips every cycle, slow one every fourth
   assign rawToggle = fastSel | (divCnt_ff == `CSVR_SLOW_HALF_LAST);

   // prescaler tap choice, divide by 1, 2, 4 or 8
   always @*
   begin
      case (prescale)
         2'h1:    psLvl = psCnt_ff[0];
         2'h2:    psLvl = psCnt_ff[1];
         2'h3:    psLvl = psCnt_ff[2];
         default: psLvl = rawClk_ff;
      endcase
   end

   // divider, prescaler and edge detect of the prescaled clock
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         divCnt_ff <= 2'h0;
         rawClk_ff <= 1'b0;
         psCnt_ff  <= 3'h0;
         psLvlD_ff <= 1'b0;
         psRise    <= 1'b0;
         psFall    <= 1'b0;
      end
      else
      begin
         divCnt_ff <= rawToggle ? 2'h0 : divCnt_ff + 2'h1;
         if (rawToggle)
            rawClk_ff <= ~rawClk_ff;
         // prescaler counts raw rising edges
         if (rawToggle && !rawClk_ff)
            psCnt_ff <= psCnt_ff + 3'h1;
         psLvlD_ff <= psLvl;
         psRise    <= psLvl & ~psLvlD_ff;
         psFall    <= ~psLvl & psLvlD_ff;
      end
   end

endmodule
`default_nettype wire

// ==== rtl/csvr_gate_sel.v ====
// comparator output synchroniser and counter gate source multiplexer
// assumes psFall marks each falling edge of the prescaled counter clock
`timescale 1ns/1ps
`default_nettype none
`include "csvr_map.vh"

module csvr_gate_sel
(
   // clock and reset
   input  wire core_clk,
   input  wire rst_b,
   // controls
   input  wire syncSel,
   input  wire gateSrcSel,
   // sources
   input  wire compOut,
   input  wire extGatePin,
   input  wire psFall,
   // results
   output wire compToConsumers,
   output wire gateLevel
);

   reg compSync_ff;   // comparator sample from the last falling edge

   // sample only on falling edges so it never races the rising-edge count
   always @(posedge core_clk)
   begin
      if (!rst_b)
         compSync_ff <= 1'b0;
      else if (syncSel && psFall)
         compSync_ff <= compOut;
   end

   // without sync the live comparator level passes straight through
   assign compToConsumers = syncSel ? compSync_ff : compOut;

   // gate source choice: pin when set, comparator when clear
   assign gateLevel = gateSrcSel ? extGatePin : compToConsumers;

endmodule
`default_nettype wire

// ==== rtl/csvr_map.vh ====
// register map and field layout of the comparator sync and reference control block
// assumes inclusion by bare name from each design file of the block
`ifndef CSVR_MAP_VH
`define CSVR_MAP_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CSVR_ADDR_CC2       4'h0
`define CSVR_ADDR_VRC       4'h4

// ----------------------------------------
// comparator_control_two fields
// ----------------------------------------
`define CSVR_CC2_SYNC       0
`define CSVR_CC2_GSS        1
`define CSVR_CC2_HYS        3
`define CSVR_CC2_FCS        4
`define CSVR_CC2_RESET      8'h02
`define CSVR_CC2_WMASK      8'h1b

// ----------------------------------------
// voltage_reference_control fields
// ----------------------------------------
`define CSVR_VRC_LVL_HI     3
`define CSVR_VRC_LVL_LO     0
`define CSVR_VRC_FVR        4
`define CSVR_VRC_RNG        5
`define CSVR_VRC_LAD        7
`define CSVR_VRC_RESET      8'h00
`define CSVR_VRC_WMASK      8'hbf

// ----------------------------------------
// reference routing codes
// ----------------------------------------
`define CSVR_ROUTE_GND      2'h0
`define CSVR_ROUTE_FIXED    2'h1
`define CSVR_ROUTE_LADDER   2'h2

// ----------------------------------------
// counter clock timing, last core_clk count of a slow-clock half period (four cycles)
// ----------------------------------------
`define CSVR_SLOW_HALF_LAST 2'h3

// ----------------------------------------
// bus responses
// ----------------------------------------
`define CSVR_RESP_OKAY      2'h0
`define CSVR_RESP_SLVERR    2'h2

`endif

// ==== rtl/csvr_top.v ====
// register bank for comparator sync, counter clock/gate selects and reference control
// assumes an AXI4-Lite master on core_clk; analog parts sit outside on plain controls
//
// Behaviour
// - sync set: sample comparator on counter falling edge
// - sampling uses the prescaled counter clock
// - counter advances on rising edge of clock
// - sync clear: comparator passes through unclocked
// - fast select picks system clock over quarter; here half of core_clk over an eighth
// - hysteresis enable bit drives hysteresis control
// - gate source: pin when set, comparator else
// - unimplemented bits always read as zero
// - ladder enable powers ladder, routes it; else fixed
// - range select: low range or high range
// - four-bit level code picks sixteen ladder levels
// - fixed reference enable bit switches fixed reference
// - fast oscillator running forces fixed reference on
// - both enables low: reference is ground
// - ladder disabled means ladder powered down
// - reference controls independent of comparator settings
// - gating acts only when counter on, gate enabled
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "csvr_map.vh"

module csvr_top
(
   // clock and reset
   input  wire        core_clk,
   input  wire        rst_b,
   // axi4-lite write address
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [3:0]  s_axi_awaddr,
   input  wire [2:0]  s_axi_awprot,
   // axi4-lite write data
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   output wire [1:0]  s_axi_bresp,
   // axi4-lite read address
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   input  wire [3:0]  s_axi_araddr,
   input  wire [2:0]  s_axi_arprot,
   // axi4-lite read data
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   // comparator and gate inputs
   input  wire        comparatorOut,
   input  wire        externalGatePin,
   // gated counter status
   input  wire        counterRunning,
   input  wire        counterGateEnable,
   input  wire [1:0]  counterPrescale,
   // oscillator status
   input  wire        fastInternalOscillator,
   // counter side results
   output reg         counterIncrement,
   output wire        comparatorToConsumers,
   output reg         counterFastClockSelect,
   // analog comparator controls
   output reg         hysteresisEnable,
   // reference controls
   output reg         ladderPowerOn,
   output reg         ladderRangeSelect,
   output reg  [3:0]  ladderLevelCode,
   output reg         fixedReferenceOn,
   output reg  [1:0]  referenceRoute
);

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   reg  [7:0]  ctrlTwo_ff;     // comparator_control_two
   reg  [7:0]  refCtrl_ff;     // voltage_reference_control
   reg  [7:0]  nxt_ctrlTwo;    // next comparator_control_two
   reg  [7:0]  nxt_refCtrl;    // next voltage_reference_control

   // ----------------------------------------
   // bus slave state
   // ----------------------------------------
   reg         awHeld_ff;      // write address taken, waiting
   reg  [3:0]  awAddr_ff;      // taken write address
   reg         wHeld_ff;       // write data taken, waiting
   reg  [7:0]  wData_ff;       // taken low byte of write data
   reg         wStrb0_ff;      // lane 0 strobe of taken data
   reg         bValid_ff;      // write response pending
   reg  [1:0]  bResp_ff;       // write response code
   reg         rValid_ff;      // read data pending
   reg  [7:0]  rData_ff;       // read data, low byte
   reg  [1:0]  rResp_ff;       // read response code
   reg  [7:0]  rdMux;          // decoded read value
   reg         rdHit;          // read address mapped
   wire        awTake;         // write address handshake
   wire        wTake;          // write data handshake
   wire        arTake;         // read address handshake
   wire        doWrite;        // both halves present, commit now
   wire        wrHitCc2;       // write lands on control two
   wire        wrHitVrc;       // write lands on reference control

   // ----------------------------------------
   // counter clock and gate
   // ----------------------------------------
   wire        psRise;         // prescaled counter clock rising edge
   wire        psFall;         // prescaled counter clock falling edge
   wire        gateLevel;      // selected gate source level
   reg  [1:0]  nxt_route;      // next reference routing

   // ----------------------------------------
   // write channel
   // ----------------------------------------
   // one write in flight; new halves are held off until the response leaves
   assign s_axi_awready = ~awHeld_ff & ~bValid_ff;
   assign s_axi_wready  = ~wHeld_ff & ~bValid_ff;
   assign awTake        = s_axi_awvalid & s_axi_awready;
   assign wTake         = s_axi_wvalid & s_axi_wready;
   assign doWrite       = awHeld_ff & wHeld_ff;
   assign wrHitCc2      = (awAddr_ff == `CSVR_ADDR_CC2);
   assign wrHitVrc      = (awAddr_ff == `CSVR_ADDR_VRC);
   assign s_axi_bvalid  = bValid_ff;
   assign s_axi_bresp   = bResp_ff;

   // address and data halves accepted in either order, response after both
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         awHeld_ff <= 1'b0;
         awAddr_ff <= 4'h0;
         wHeld_ff  <= 1'b0;
         wData_ff  <= 8'h00;
         wStrb0_ff <= 1'b0;
         bValid_ff <= 1'b0;
         bResp_ff  <= `CSVR_RESP_OKAY;
      end
      else
      begin
         if (awTake)
         begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
         end
         else if (doWrite)
            awHeld_ff <= 1'b0;
         if (wTake)
         begin
            wHeld_ff  <= 1'b1;
            wData_ff  <= s_axi_wdata[7:0];
            wStrb0_ff <= s_axi_wstrb[0];
         end
         else if (doWrite)
            wHeld_ff <= 1'b0;
         // unmapped address gets slverr, registers untouched
         if (doWrite)
         begin
            bValid_ff <= 1'b1;
            bResp_ff  <= (wrHitCc2 | wrHitVrc) ? `CSVR_RESP_OKAY : `CSVR_RESP_SLVERR;
         end
         else if (s_axi_bready)
            bValid_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // register update
   // ----------------------------------------
   // only lane 0 carries data; unimplemented bits are masked off on write
   always @*
   begin
      nxt_ctrlTwo = ctrlTwo_ff;
      nxt_refCtrl = refCtrl_ff;
      if (doWrite && wStrb0_ff && wrHitCc2)
         nxt_ctrlTwo = wData_ff & `CSVR_CC2_WMASK;
      if (doWrite && wStrb0_ff && wrHitVrc)
         nxt_refCtrl = wData_ff & `CSVR_VRC_WMASK;
   end

   // registers return to reset state on device reset, gate select reads one
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         ctrlTwo_ff <= `CSVR_CC2_RESET;
         refCtrl_ff <= `CSVR_VRC_RESET;
      end
      else
      begin
         ctrlTwo_ff <= nxt_ctrlTwo;
         refCtrl_ff <= nxt_refCtrl;
      end
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   assign s_axi_arready = ~rValid_ff;
   assign arTake        = s_axi_arvalid & s_axi_arready;
   assign s_axi_rvalid  = rValid_ff;
   assign s_axi_rdata   = {24'h000000, rData_ff};
   assign s_axi_rresp   = rResp_ff;

   // read decode; stored values already hold zeros in unimplemented places
   always @*
   begin
      rdMux = 8'h00;
      rdHit = 1'b1;
      case (s_axi_araddr)
         `CSVR_ADDR_CC2: rdMux = ctrlTwo_ff & `CSVR_CC2_WMASK;
         `CSVR_ADDR_VRC: rdMux = refCtrl_ff & `CSVR_VRC_WMASK;
         default:        rdHit = 1'b0;
      endcase
   end

   // read answered one cycle after the address is taken
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         rValid_ff <= 1'b0;
         rData_ff  <= 8'h00;
         rResp_ff  <= `CSVR_RESP_OKAY;
      end
      else if (arTake)
      begin
         rValid_ff <= 1'b1;
         rData_ff  <= rdMux;
         rResp_ff  <= rdHit ? `CSVR_RESP_OKAY : `CSVR_RESP_SLVERR;
      end
      else if (s_axi_rready)
         rValid_ff <= 1'b0;
   end

   // ----------------------------------------
   // counter clock source and prescaler
   // ----------------------------------------
   csvr_clk_src u_clk_src
   (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .fastSel  (ctrlTwo_ff[`CSVR_CC2_FCS]),
      .prescale (counterPrescale),
      .psRise   (psRise),
      .psFall   (psFall)
   );

   // ----------------------------------------
   // comparator sync and gate source
   // ----------------------------------------
   csvr_gate_sel u_gate_sel
   (
      .core_clk        (core_clk),
      .rst_b           (rst_b),
      .syncSel         (ctrlTwo_ff[`CSVR_CC2_SYNC]),
      .gateSrcSel      (ctrlTwo_ff[`CSVR_CC2_GSS]),
      .compOut         (comparatorOut),
      .extGatePin      (externalGatePin),
      .psFall          (psFall),
      .compToConsumers (comparatorToConsumers),
      .gateLevel       (gateLevel)
   );

   // ----------------------------------------
   // counter increment
   // ----------------------------------------
   // counting on the rising edge keeps clear of the falling-edge sample;
   // the gate only matters while the counter runs with gating switched on
   always @(posedge core_clk)
   begin
      if (!rst_b)
         counterIncrement <= 1'b0;
      else
         counterIncrement <= psRise & counterRunning &
                             (~counterGateEnable | gateLevel);
   end

   // ----------------------------------------
   // reference routing
   // ----------------------------------------
   // route depends on reference bits only, never on comparator settings
   always @*
   begin
      if (refCtrl_ff[`CSVR_VRC_LAD])
         nxt_route = `CSVR_ROUTE_LADDER;
      else if (refCtrl_ff[`CSVR_VRC_FVR])
         nxt_route = `CSVR_ROUTE_FIXED;
      else
         nxt_route = `CSVR_ROUTE_GND;
   end

   // ----------------------------------------
   // analog control outputs
   // ----------------------------------------
   // registered so the analog side sees glitch-free levels
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         counterFastClockSelect <= 1'b0;
         hysteresisEnable       <= 1'b0;
         ladderPowerOn          <= 1'b0;
         ladderRangeSelect      <= 1'b0;
         ladderLevelCode        <= 4'h0;
         fixedReferenceOn       <= 1'b0;
         referenceRoute         <= `CSVR_ROUTE_GND;
      end
      else
      begin
         counterFastClockSelect <= ctrlTwo_ff[`CSVR_CC2_FCS];
         hysteresisEnable       <= ctrlTwo_ff[`CSVR_CC2_HYS];
         // ladder draws no current while its enable is low
         ladderPowerOn          <= refCtrl_ff[`CSVR_VRC_LAD];
         ladderRangeSelect      <= refCtrl_ff[`CSVR_VRC_RNG];
         ladderLevelCode        <= refCtrl_ff[`CSVR_VRC_LVL_HI:`CSVR_VRC_LVL_LO];
         // oscillator needs the fixed reference, so it overrides the bit
         fixedReferenceOn       <= refCtrl_ff[`CSVR_VRC_FVR] |
                                   fastInternalOscillator;
         referenceRoute         <= nxt_route;
      end
   end

endmodule
`default_nettype wire

// ==== tb/csvr_assertions.sv ====
// checker for csvr_top: reference routing, read masks, counter pulse timing
// assumes it is bound onto csvr_top and sees its ports only
`timescale 1ns/1ps
`default_nettype none
`include "csvr_map.vh"

module csvr_assertions
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rst_b,
   // read channels
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [3:0]  s_axi_araddr,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   // counter side
   input wire logic        counterIncrement,
   input wire logic        counterRunning,
   input wire logic        counterGateEnable,
   input wire logic [1:0]  counterPrescale,
   input wire logic        counterFastClockSelect,
   input wire logic        fastInternalOscillator,
   // reference controls
   input wire logic        ladderPowerOn,
   input wire logic        fixedReferenceOn,
   input wire logic [1:0]  referenceRoute
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   logic [3:0] rdAddr_ff; // address of the read under way

   // remember which register the pending read answers for
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         rdAddr_ff <= 4'h0;
      else if (s_axi_arvalid && s_axi_arready)
         rdAddr_ff <= s_axi_araddr;
   end

   // free running, ungated, undivided; long history keeps mode switches out
   wire freeRun = counterRunning && !counterGateEnable && counterPrescale == 2'h0;
   sequence s_fast;
      freeRun && counterFastClockSelect;
   endsequence
   sequence s_slow;
      freeRun && !counterFastClockSelect;
   endsequence

   property p_ladder;
      ladderPowerOn == (referenceRoute == `CSVR_ROUTE_LADDER);
   endproperty
   a_ladder: assert property (p_ladder) else $error("ladder power and route differ");

   property p_fixed;
      referenceRoute != 2'h3 &&
      (referenceRoute != `CSVR_ROUTE_FIXED || (fixedReferenceOn && !ladderPowerOn));
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed route without fixed source");

   property p_osc;
      fastInternalOscillator |=> fixedReferenceOn;
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator did not force fixed on");

   property p_rsvd;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && (rdAddr_ff == `CSVR_ADDR_VRC ?
         !s_axi_rdata[6] : (s_axi_rdata[7:5] == 3'h0 && !s_axi_rdata[2]));
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("unimplemented bit read as one");

   property p_pulse;
      counterIncrement |=> !counterIncrement;
   endproperty
   a_pulse: assert property (p_pulse) else $error("increment longer than a cycle");

   property p_run;
      counterIncrement |-> $past(counterRunning);
   endproperty
   a_run: assert property (p_run) else $error("increment while counter stopped");

   property p_fast;
      s_fast[*4] ##1 (s_fast and counterIncrement) ##1 s_fast[*2] |-> counterIncrement;
   endproperty
   a_fast: assert property (p_fast) else $error("fast clock period not two");

   property p_slow;
      s_slow[*4] ##1 (s_slow and counterIncrement) ##1 s_slow[*8] |-> counterIncrement;
   endproperty
   a_slow: assert property (p_slow) else $error("slow clock period not eight");
endmodule

bind csvr_top csvr_assertions csvr_assertions_i (.*);
`default_nettype wire

// ==== tb/csvr_far_model.sv ====
// far side: gated counter status lines, comparator output, increment tally
// assumes commands change just after core_clk rising edges
`timescale 1ns/1ps
`default_nettype none

module csvr_far_model
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // bench commands: comparator, pin, run, gate, prescale, oscillator
   input  wire logic [6:0]  cmd,
   // block side
   input  wire logic        inc,
   output var  logic        compOut,
   output var  logic        gatePin,
   output var  logic        run,
   output var  logic        gateEn,
   output var  logic [1:0]  presc,
   output var  logic        fastOsc,
   output var  logic [15:0] incCount
);
   // lines follow commands one edge late; tally of increments let through
   always @(posedge core_clk)
   begin
      {compOut, gatePin, run, gateEn, presc, fastOsc} <= cmd;
      if (!rst_b)
         incCount <= 16'h0;
      else if (inc)
         incCount <= incCount + 16'h1;
   end
endmodule
`default_nettype wire

// ==== tb/csvr_top_tb.sv ====
// self-checking bench for csvr_top with far-side model
// assumes core_clk at 125 MHz and this module as the only bus master
`timescale 1ns/1ps
`default_nettype none
`include "csvr_map.vh"

module csvr_top_tb;
   logic        core_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   logic [3:0]  awAddr = 4'h0, arAddr = 4'h0, wStrb = 4'h0;
   logic [31:0] wData = 32'h0;
   logic [6:0]  cmd = 7'h00;
   wire         awReady, wReady, bValid, arReady, rValid, compOut, gatePin, run, gateEn;
   wire         fastOsc, inc, toCons, fastSel, hys, ladOn, rngSel, fixOn;
   wire  [1:0]  bResp, rResp, presc, route;
   wire  [3:0]  lvl;
   wire  [15:0] incCount;
   wire  [31:0] rData;
   int          num_errors = 0;
   int          compares = 0;

   always #4 core_clk = ~core_clk;

   csvr_top csvr_top_i (.core_clk(core_clk), .rst_b(rst_b),
      .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
      .s_axi_awprot(3'h0), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData),
      .s_axi_wstrb(wStrb), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
      .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr),
      .s_axi_arprot(3'h0), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData),
      .s_axi_rresp(rResp), .comparatorOut(compOut), .externalGatePin(gatePin),
      .counterRunning(run), .counterGateEnable(gateEn), .counterPrescale(presc),
      .fastInternalOscillator(fastOsc), .counterIncrement(inc), .comparatorToConsumers(toCons),
      .counterFastClockSelect(fastSel), .hysteresisEnable(hys), .ladderPowerOn(ladOn),
      .ladderRangeSelect(rngSel), .ladderLevelCode(lvl), .fixedReferenceOn(fixOn),
      .referenceRoute(route));

   csvr_far_model csvr_far_model_i (.core_clk(core_clk), .rst_b(rst_b), .cmd(cmd), .inc(inc),
      .compOut(compOut), .gatePin(gatePin), .run(run), .gateEn(gateEn), .presc(presc),
      .fastOsc(fastOsc), .incCount(incCount));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("num_errors=%0d compares=%0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // bounded wait step; a hang ends the run as a failure
   task automatic guard(inout int n);
      n++;
      if (n > 300)
      begin
         num_errors++;
         $display("ERROR t=%0t bus wait timed out", $time);
         end_of_test;
      end
   endtask

   // one write; address and data offered together, each dropped when taken
   task automatic axiWrite(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
      int         n = 0;
      logic       aw = 1'b1, w = 1'b1, t = 1'b0;
      logic [1:0] r;
      @(posedge core_clk);
      {awAddr, wData, wStrb, awValid, wValid} <= {a, 24'h0, d, 4'h1, 2'b11};
      while (aw || w)
      begin
         @(negedge core_clk);
         guard(n);
         aw = aw && !awReady;
         w = w && !wReady;
         @(posedge core_clk);
         {awValid, wValid} <= {aw, w};
      end
      bReady <= 1'b1;
      while (!t)
      begin
         @(negedge core_clk);
         guard(n);
         {t, r} = {bValid, bResp};
         @(posedge core_clk);
      end
      bReady <= 1'b0;
      check({30'h0, r}, {30'h0, er});
   endtask

   // one read, judged against expected data and response
   task automatic axiRead(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      int          n = 0;
      logic        t = 1'b0;
      logic [1:0]  r;
      logic [31:0] d;
      @(posedge core_clk);
      {arAddr, arValid} <= {a, 1'b1};
      while (!t)
      begin
         @(negedge core_clk);
         guard(n);
         t = arReady;
         @(posedge core_clk);
      end
      {arValid, rReady} <= 2'b01;
      t = 1'b0;
      while (!t)
      begin
         @(negedge core_clk);
         guard(n);
         {t, r, d} = {rValid, rResp, rData};
         @(posedge core_clk);
      end
      rReady <= 1'b0;
      check(d, ed);
      check({30'h0, r}, {30'h0, er});
   endtask

   // far-side command: comparator, pin, run, gate, prescale[1:0], oscillator
   task automatic far(input logic [6:0] c);
      @(posedge core_clk);
      cmd <= c;
   endtask

   // settle, then count increments over a whole number of periods
   task automatic countInc(input int cyc, input logic [15:0] exp);
      logic [15:0] c0;
      repeat (72) @(negedge core_clk);
      c0 = incCount;
      repeat (cyc) @(negedge core_clk);
      check({16'h0, incCount - c0}, {16'h0, exp});
   endtask

   task automatic t_reset;
      axiRead(`CSVR_ADDR_CC2, 32'h02, `CSVR_RESP_OKAY);
      axiRead(`CSVR_ADDR_VRC, 32'h00, `CSVR_RESP_OKAY);
      check({28'h0, ladOn, fixOn, route}, 32'h0);
   endtask

   task automatic t_masks;
      axiWrite(`CSVR_ADDR_CC2, 8'hff, `CSVR_RESP_OKAY);
      axiRead(`CSVR_ADDR_CC2, 32'h1b, `CSVR_RESP_OKAY);
      axiWrite(`CSVR_ADDR_VRC, 8'hff, `CSVR_RESP_OKAY);
      axiRead(`CSVR_ADDR_VRC, 32'hbf, `CSVR_RESP_OKAY);
      axiWrite(4'h8, 8'h00, `CSVR_RESP_SLVERR);
      axiRead(4'hc, 32'h0, `CSVR_RESP_SLVERR);
      axiRead(`CSVR_ADDR_VRC, 32'hbf, `CSVR_RESP_OKAY);
      check({28'h0, fastSel, hys, ladOn, fixOn}, 32'hf);
   endtask

   task automatic t_ref;
      logic [7:0] v [4] = '{8'h00, 8'h10, 8'h80, 8'hb5};
      logic [3:0] e [4] = '{4'h0, 4'h5, 4'ha, 4'he};
      for (int i = 0; i < 4; i++)
      begin
         axiWrite(`CSVR_ADDR_VRC, v[i], `CSVR_RESP_OKAY);
         repeat (2) @(negedge core_clk);
         check({28'h0, ladOn, fixOn, route}, {28'h0, e[i]});
      end
      for (int i = 0; i < 16; i++)
      begin
         axiWrite(`CSVR_ADDR_VRC, {2'b00, i[0], 1'b0, i[3:0]}, `CSVR_RESP_OKAY);
         repeat (2) @(negedge core_clk);
         check({27'h0, rngSel, lvl}, {27'h0, i[0], i[3:0]});
      end
   endtask

   task automatic t_osc;
      axiWrite(`CSVR_ADDR_VRC, 8'h00, `CSVR_RESP_OKAY);
      far(7'h01);
      repeat (3) @(negedge core_clk);
      check({28'h0, ladOn, fixOn, route}, 32'h4);
      axiWrite(`CSVR_ADDR_CC2, 8'h1b, `CSVR_RESP_OKAY);
      repeat (2) @(negedge core_clk);
      check({28'h0, ladOn, fixOn, route}, 32'h4);
      far(7'h00);
      repeat (3) @(negedge core_clk);
      check({31'h0, fixOn}, 32'h0);
   endtask

   task automatic t_count;
      axiWrite(`CSVR_ADDR_CC2, 8'h12, `CSVR_RESP_OKAY);
      far(7'h10);
      countInc(40, 16'h14);
      far(7'h14);
      countInc(80, 16'h0a);
      axiWrite(`CSVR_ADDR_CC2, 8'h02, `CSVR_RESP_OKAY);
      far(7'h10);
      countInc(80, 16'h0a);
      far(7'h18);
      countInc(80, 16'h0);
      far(7'h38);
      countInc(80, 16'h0a);
      far(7'h28);
      countInc(80, 16'h0);
   endtask

   task automatic t_sync;
      int n = 0;
      axiWrite(`CSVR_ADDR_CC2, 8'h00, `CSVR_RESP_OKAY);
      far(7'h18);
      countInc(80, 16'h0);
      far(7'h58);
      repeat (2) @(negedge core_clk);
      check({30'h0, compOut, toCons}, 32'h3);
      countInc(80, 16'h0a);
      axiWrite(`CSVR_ADDR_CC2, 8'h01, `CSVR_RESP_OKAY);
      far(7'h1e);
      countInc(128, 16'h0);
      far(7'h5e);
      repeat (2) @(negedge core_clk);
      check({30'h0, compOut, toCons}, 32'h2);
      while (toCons !== 1'b1 && n < 80)
      begin
         @(negedge core_clk);
         n++;
      end
      check({31'h0, n < 70}, 32'h1);
      countInc(128, 16'h2);
   endtask

   initial
   begin
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      t_reset;
      t_masks;
      t_ref;
      t_osc;
      t_count;
      t_sync;
      end_of_test;
   end
endmodule
`default_nettype wire
